// ### hdl/vref_regs.sv
// Purpose: Register bank and control decode for the voltage reference
// Assumes: Single-word AHB-Lite transfers, zero wait states
// Notes:   Analog outputs are modelled as control levels and a level code
`timescale 1ns/100ps
`default_nettype none
module vref_regs (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        fixed_ref_ready_in,
    input  wire logic        ref_output_pin_in,
    output logic             fixed_ref_on,
    output logic      [2:0]  fixed_ref_gain_mult,
    output logic             ladder_on,
    output logic             ladder_pin_drive,
    output logic             ref_pin_digital_in,
    output logic      [1:0]  ladder_pos_src,
    output logic             ladder_neg_src,
    output logic      [5:0]  ladder_out_code
);
    // ************************************************************
    // Bus capture
    // ************************************************************
    logic [7:0] fixed_r;
    logic [7:0] ladder_r;
    logic [7:0] level_r;
    logic       wr_pend_r;
    logic [3:0] wr_addr_r;
    logic       stable_r;
    logic       rdy_m_r;
    logic       rdy_s_r;
    logic       pin_m_r;
    logic       pin_s_r;
    logic [9:0] settle_r;
    logic       take;

    assign take = hsel && hready && (htrans == vref_pkg::VREF_TRANS_NONSEQ);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 4'h0;
        end else begin
            wr_pend_r <= take && hwrite;
            wr_addr_r <= haddr[3:0];
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fixed_r  <= vref_pkg::VREF_FIXED_RST;
            ladder_r <= vref_pkg::VREF_LADDER_RST;
            level_r  <= vref_pkg::VREF_LEVEL_RST;
        end else if (wr_pend_r) begin
            // Masked writes keep reserved and read-only bits at zero
            case (wr_addr_r)
                vref_pkg::VREF_OFF_FIXED:
                    fixed_r <= hwdata[7:0] & vref_pkg::VREF_FIXED_MASK;
                vref_pkg::VREF_OFF_LADDER:
                    ladder_r <= hwdata[7:0] & vref_pkg::VREF_LADDER_MASK;
                vref_pkg::VREF_OFF_LEVEL:
                    level_r <= hwdata[7:0] & vref_pkg::VREF_LEVEL_MASK;
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Stable flag
    // ************************************************************
    // Analog ready is asynchronous, so it is synchronised first
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdy_m_r <= 1'b0;
            rdy_s_r <= 1'b0;
            pin_m_r <= 1'b0;
            pin_s_r <= 1'b0;
        end else begin
            rdy_m_r <= fixed_ref_ready_in;
            rdy_s_r <= rdy_m_r;
            pin_m_r <= ref_output_pin_in;
            pin_s_r <= pin_m_r;
        end
    end

    // Stable needs both the analog flag and a minimum settle count
    always_ff @(posedge clk_sys) begin
        if (srst || !fixed_r[vref_pkg::VREF_BIT_EN]) begin
            settle_r <= 10'h000;
            stable_r <= 1'b0;
        end else begin
            if (settle_r != 10'(vref_pkg::VREF_SETTLE_CYC)) begin
                settle_r <= settle_r + 10'h001;
            end
            stable_r <= rdy_s_r && (settle_r == 10'(vref_pkg::VREF_SETTLE_CYC));
        end
    end

    // ************************************************************
    // Read data and outputs
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            if (take && !hwrite) begin
                case (haddr[3:0])
                    vref_pkg::VREF_OFF_FIXED:
                        hrdata <= {24'h000000, fixed_r[7], stable_r, fixed_r[5:0]};
                    vref_pkg::VREF_OFF_LADDER:
                        hrdata <= {24'h000000, ladder_r};
                    vref_pkg::VREF_OFF_LEVEL:
                        hrdata <= {24'h000000, level_r};
                    default:
                        hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fixed_ref_on        <= 1'b0;
            fixed_ref_gain_mult <= 3'h1;
            ladder_on           <= 1'b0;
            ladder_pin_drive    <= 1'b0;
            ref_pin_digital_in  <= 1'b0;
            ladder_pos_src      <= 2'h0;
            ladder_neg_src      <= 1'b0;
            ladder_out_code     <= 6'h00;
        end else begin
            fixed_ref_on <= fixed_r[vref_pkg::VREF_BIT_EN];
            case (fixed_r[5:4])
                2'b01:   fixed_ref_gain_mult <= 3'h1;
                2'b10:   fixed_ref_gain_mult <= 3'h2;
                2'b11:   fixed_ref_gain_mult <= 3'h4;
                default: fixed_ref_gain_mult <= 3'h0;
            endcase
            ladder_on        <= ladder_r[vref_pkg::VREF_BIT_EN];
            ladder_pin_drive <= ladder_r[vref_pkg::VREF_BIT_PIN];
            ref_pin_digital_in <= pin_s_r && !ladder_r[vref_pkg::VREF_BIT_PIN];
            ladder_pos_src   <= ladder_r[3:2];
            ladder_neg_src   <= ladder_r[vref_pkg::VREF_BIT_NEG];
            // Code in 32nds of the span; 32 means full positive source
            if (ladder_r[vref_pkg::VREF_BIT_EN]) begin
                ladder_out_code <= {1'b0, level_r[4:0]};
            end else if (ladder_r[vref_pkg::VREF_BIT_IDLE]) begin
                ladder_out_code <= 6'h20;
            end else begin
                ladder_out_code <= 6'h00;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    fixed_rsv_a: assert property (@(posedge clk_sys) disable iff (srst)
        (fixed_r[3:0] == 4'h0)) else $error("fixed reserved bits set");
    level_rsv_a: assert property (@(posedge clk_sys) disable iff (srst)
        (level_r[7:5] == 3'h0)) else $error("level reserved bits set");
    stable_off_a: assert property (@(posedge clk_sys) disable iff (srst)
        !fixed_r[7] |=> !stable_r) else $error("stable while disabled");
    pin_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
        ladder_r[5] |=> !ref_pin_digital_in) else $error("pin input not zero");
    code_track_a: assert property (@(posedge clk_sys) disable iff (srst)
        ladder_r[7] |=> ladder_out_code == {1'b0, $past(level_r[4:0])}) else $error("code wrong");
    idle_hi_a: assert property (@(posedge clk_sys) disable iff (srst)
        (!ladder_r[7] && ladder_r[6]) |=> ladder_out_code == 6'h20) else $error("idle wrong");
    gain_dec_a: assert property (@(posedge clk_sys) disable iff (srst)
        fixed_r[5:4] == 2'b11 |=> fixed_ref_gain_mult == 3'h4) else $error("gain wrong");
    reset_val_a: assert property (@(posedge clk_sys)
        srst |=> (fixed_r == 8'h10) && (ladder_r == 8'h00) && (level_r == 8'h00))
        else $error("reset values wrong");
    write_mask_a: assert property (@(posedge clk_sys) disable iff (srst)
        (wr_pend_r && wr_addr_r == 4'h4) |=> ladder_r == ($past(hwdata[7:0]) & 8'hed))
        else $error("ladder write wrong");
    neg_src_a: assert property (@(posedge clk_sys) disable iff (srst)
        ##1 ladder_neg_src == $past(ladder_r[0])) else $error("neg source wrong");
endmodule : vref_regs
`default_nettype wire

// ### pkg/vref_pkg.sv
// Purpose: Constants for the voltage reference control register bank
// Assumes: AHB-Lite slave, 32-bit words, 20 MHz clk_sys
// Notes:   Offsets are byte addresses of one word per register
// Operation
// - Fixed reference control bit 7 is a writable enable, 1 turns it on.
// - Bit 6 is read-only stable flag, 1 once the fixed reference settles.
// - Gain code 01 unity, 10 double, 11 quadruple; software avoids 00.
// - Unimplemented bits of all three registers read back zero.
// - Ladder control bit 6 picks idle output: 0 negative, 1 positive source.
// - Positive source 00 supply, 01 external reference, 10 fixed reference.
// - Level register holds a writable 5-bit code in its low bits.
// - Ladder output is negative plus span times code over thirty-two.
// - Level code stays right-justified at the low end of the register.
// - Ladder control bit 7 enables the ladder; clear stops ladder current.
// - Bit 5 routes ladder to output pin; pin digital input then reads zero.
// - Reset disables ladder and fixed reference, removes pin, clears code.
package vref_pkg;
    localparam logic [3:0] VREF_OFF_FIXED  = 4'h0;
    localparam logic [3:0] VREF_OFF_LADDER = 4'h4;
    localparam logic [3:0] VREF_OFF_LEVEL  = 4'h8;
    localparam logic [7:0] VREF_FIXED_MASK  = 8'hb0;
    localparam logic [7:0] VREF_LADDER_MASK = 8'hed;
    localparam logic [7:0] VREF_LEVEL_MASK  = 8'h1f;
    localparam logic [7:0] VREF_FIXED_RST   = 8'h10;
    localparam logic [7:0] VREF_LADDER_RST  = 8'h00;
    localparam logic [7:0] VREF_LEVEL_RST   = 8'h00;
    localparam int         VREF_BIT_EN      = 7;
    localparam int         VREF_BIT_STABLE  = 6;
    localparam int         VREF_BIT_IDLE    = 6;
    localparam int         VREF_BIT_PIN     = 5;
    localparam int         VREF_BIT_NEG     = 0;
    localparam int         VREF_SETTLE_NS   = 25000;
    localparam int         VREF_CLK_NS      = 50;
    localparam int         VREF_SETTLE_CYC  = (VREF_SETTLE_NS + VREF_CLK_NS - 1) / VREF_CLK_NS;
    localparam logic [1:0] VREF_TRANS_NONSEQ = 2'b10;
endpackage : vref_pkg

// ### dv/tb.sv
// Purpose: Self-checking bench for the voltage reference register bank
// Assumes: Zero-wait AHB-Lite slave, hready tied back from hreadyout
// Notes:   Reads are checked by a monitor against queued expectations
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        clk_sys, srst, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, pos_src;
    logic [2:0]  hsize, gain_mult;
    logic        rdy_in, pin_in, fr_on, l_on, l_pin, pin_dig, neg_src;
    logic [5:0]  out_code;
    logic        rd_ph;
    logic [31:0] exp_q[$];
    logic [31:0] seed;
    int          bad_count, n_tests;
    assign hready = hreadyout;
    vref_regs DUT (.clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .fixed_ref_ready_in(rdy_in), .ref_output_pin_in(pin_in),
        .fixed_ref_on(fr_on), .fixed_ref_gain_mult(gain_mult), .ladder_on(l_on),
        .ladder_pin_drive(l_pin), .ref_pin_digital_in(pin_dig),
        .ladder_pos_src(pos_src), .ladder_neg_src(neg_src), .ladder_out_code(out_code));
    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic close_out();
        $display("tests=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    // Monitor owns read compares so the driver never races hrdata
    always @(posedge clk_sys) if (rd_ph) check(hrdata, exp_q.pop_front());
    // ****************************************
    // Bus master
    // ****************************************
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin @(posedge clk_sys); k++; end while (hreadyout !== 1'b1 && k < 40);
        if (hreadyout !== 1'b1) begin bad_count++; close_out(); end
    endtask : wait_rdy
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        haddr <= a; hwrite <= w; hsel <= 1'b1; htrans <= vref_pkg::VREF_TRANS_NONSEQ;
        wait_rdy();
        htrans <= 2'h0; hwdata <= d; rd_ph <= !w;
        wait_rdy();
        rd_ph <= 1'b0;
    endtask : xfer
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(a, 1'b0, 32'h0);
    endtask : rd
    task automatic rst_rd();
        rd(32'h0, 32'h10);
        rd(32'h4, 32'h0);
        rd(32'h8, 32'h0);
    endtask : rst_rd
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13; s ^= s >> 17; s ^= s << 5;
        return s;
    endfunction : xs
    initial begin clk_sys = 1'b0; forever #25 clk_sys = ~clk_sys; end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [7:0] ctl [3] = '{8'ha9, 8'h44, 8'h00};
        logic [5:0] code [3] = '{6'h15, 6'h20, 6'h00};
        srst = 1'b1; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = '0; rdy_in = 1'b0; pin_in = 1'b1; rd_ph = 1'b0;
        seed = 32'he6b7; bad_count = 0; n_tests = 0;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        rst_rd();
        check({29'h0, gain_mult}, 32'h1);
        xfer(32'h0, 1'b1, 32'hff); rd(32'h0, 32'hb0);
        xfer(32'h4, 1'b1, 32'hfb); rd(32'h4, 32'he9);
        xfer(32'h8, 1'b1, 32'hff); rd(32'h8, 32'h1f);
        xfer(32'hc, 1'b1, 32'hff); rd(32'hc, 32'h0);
        for (int g = 0; g < 4; g++) begin
            // Reserved gain 00 is never programmed, so pass 0 reuses unity gain
            xfer(32'h0, 1'b1, {24'h0, g[0], 1'b0, (g == 0) ? 2'b01 : g[1:0], 4'h0});
            repeat (2) @(posedge clk_sys);
            check({29'h0, gain_mult}, (g == 0) ? 32'h1 : 32'h1 << (g - 1));
            check({31'h0, fr_on}, {31'h0, g[0]});
        end
        xfer(32'h8, 1'b1, 32'h15);
        for (int i = 0; i < 3; i++) begin
            xfer(32'h4, 1'b1, {24'h0, ctl[i]});
            repeat (2) @(posedge clk_sys);
            check({26'h0, out_code}, {26'h0, code[i]});
            check({31'h0, l_on}, {31'h0, ctl[i][7]});
            check({30'h0, l_pin, pin_dig}, {30'h0, ctl[i][5], !ctl[i][5]});
            check({29'h0, pos_src, neg_src}, {29'h0, ctl[i][3:2], ctl[i][0]});
        end
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            xfer(32'h8, 1'b1, seed);
            rd(32'h8, {27'h0, seed[4:0]});
        end
        // Disable first so the settle count restarts from zero
        xfer(32'h0, 1'b1, 32'h10);
        rdy_in <= 1'b1;
        xfer(32'h0, 1'b1, 32'h90);
        repeat (400) @(posedge clk_sys);
        rd(32'h0, 32'h90);
        repeat (150) @(posedge clk_sys);
        rd(32'h0, 32'hd0);
        // Second reset from a busy state, not only from power-up
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        rst_rd();
        check({30'h0, fr_on, l_pin}, 32'h0);
        close_out();
    end
endmodule : tb
`default_nettype wire
